/* hw/trs_defines.vh */
`ifndef TRS_DEFINES_VH
`define TRS_DEFINES_VH

// Register byte offsets
`define TRS_OFF_MODE      12'h004
`define TRS_OFF_RAW       12'h01C
`define TRS_OFF_CLEAR     12'h024
`define TRS_OFF_MATCH     12'h030
`define TRS_OFF_IRQ_STAT  12'h040
`define TRS_OFF_IRQ_MASK  12'h044

// Address decode codes
`define TRS_SEL_NONE      3'h0
`define TRS_SEL_MODE      3'h1
`define TRS_SEL_RAW       3'h2
`define TRS_SEL_CLEAR     3'h3
`define TRS_SEL_MATCH     3'h4
`define TRS_SEL_IRQ_STAT  3'h5
`define TRS_SEL_IRQ_MASK  3'h6

// Event flag positions
`define TRS_BIT_CAPB_EVENT   10
`define TRS_BIT_CAPB_MATCH   9
`define TRS_BIT_TMRB_TIMEOUT 8
`define TRS_BIT_TMRA_MATCH   4
`define TRS_BIT_CLOCK_EVENT  3
`define TRS_BIT_CAPA_EVENT   2
`define TRS_BIT_CAPA_MATCH   1
`define TRS_BIT_TMRA_TIMEOUT 0
`define TRS_FLAG_W           11
`define TRS_FLAG_MASK        11'h71F

// Timer A mode register fields
`define TRS_MODE_LSB      0
`define TRS_MODE_MSB      1
`define TRS_MODE_ONESHOT  2'h1
`define TRS_MODE_PERIODIC 2'h2
`define TRS_MODE_MIE_BIT  5
`define TRS_MODE_MASK     32'h0000_0023

// Reset values
`define TRS_RST_MODE      32'h0000_0000
`define TRS_RST_MATCH     32'hFFFF_FFFF
`define TRS_RST_FLAGS     11'h000
`define TRS_RST_MASK      11'h000

`endif

/* hw/trs_flags.v */
`timescale 1ns/1ps
`default_nettype none
`include "trs_defines.vh"

module trs_flags
(
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire [`TRS_FLAG_W-1:0]  set,
  input  wire [`TRS_FLAG_W-1:0]  clr,
  output reg  [`TRS_FLAG_W-1:0]  flags
);

  wire [`TRS_FLAG_W-1:0] flags_nxt;

  // Set is ORed in after the clear so a coinciding event survives
  assign flags_nxt = ((flags & ~clr) | set) & `TRS_FLAG_MASK;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flags <= `TRS_RST_FLAGS;
    end
    else
    begin
      flags <= flags_nxt;
    end
  end

endmodule

`default_nettype wire

/* hw/trs_top.v */
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "trs_defines.vh"

module trs_top
(
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        CAPB_EVENT,
  input  wire        CAPB_MATCH,
  input  wire        TMRB_TIMEOUT,
  input  wire        CLOCK_EVENT,
  input  wire        CAPA_EVENT,
  input  wire        CAPA_MATCH,
  input  wire        TMRA_TIMEOUT,
  input  wire [31:0] TMRA_COUNT,
  output wire [10:0] RAW_FLAGS,
  output reg         IRQ
);

  // Register select from a byte address; misaligned addresses map nowhere
  function [2:0] trs_decode;
    input [11:0] addr;
    begin
      case (addr)
        `TRS_OFF_MODE:     trs_decode = `TRS_SEL_MODE;
        `TRS_OFF_RAW:      trs_decode = `TRS_SEL_RAW;
        `TRS_OFF_CLEAR:    trs_decode = `TRS_SEL_CLEAR;
        `TRS_OFF_MATCH:    trs_decode = `TRS_SEL_MATCH;
        `TRS_OFF_IRQ_STAT: trs_decode = `TRS_SEL_IRQ_STAT;
        `TRS_OFF_IRQ_MASK: trs_decode = `TRS_SEL_IRQ_MASK;
        default:           trs_decode = `TRS_SEL_NONE;
      endcase
    end
  endfunction

  // Widen a flag vector to a bus word, bits above read zero
  function [31:0] trs_word;
    input [`TRS_FLAG_W-1:0] flags;
    begin
      trs_word = {21'h000000, flags & `TRS_FLAG_MASK};
    end
  endfunction

  // Match counting only makes sense in one-shot or periodic mode
  function trs_match_mode;
    input [1:0] mode;
    begin
      trs_match_mode = (mode == `TRS_MODE_ONESHOT) || (mode == `TRS_MODE_PERIODIC);
    end
  endfunction

  reg  [31:0]             mode_r;
  reg  [31:0]             match_r;
  reg  [`TRS_FLAG_W-1:0]  irq_mask_r;
  reg                     equal_r;
  reg  [31:0]             rdata_nxt;
  reg                     slverr_nxt;

  wire [2:0]              sel;
  wire                    access;
  wire                    done;
  wire                    wr_done;
  wire                    rd_done;
  wire                    equal_now;
  wire                    match_pulse;
  wire [`TRS_FLAG_W-1:0]  events;
  wire [`TRS_FLAG_W-1:0]  raw_clr;
  wire [`TRS_FLAG_W-1:0]  irq_clr;
  wire [`TRS_FLAG_W-1:0]  raw_flags;
  wire [`TRS_FLAG_W-1:0]  irq_flags;

  assign sel     = trs_decode(PADDR);
  assign access  = PSEL & PENABLE;
  // One wait state: the transfer completes at the edge that sees PREADY high
  assign done    = access & PREADY;
  assign wr_done = done & PWRITE;
  assign rd_done = done & ~PWRITE;

  // Match on the entry into equality only, so a stalled counter flags once
  assign equal_now   = (TMRA_COUNT == match_r);
  assign match_pulse = equal_now & ~equal_r & mode_r[`TRS_MODE_MIE_BIT] &
                       trs_match_mode(mode_r[`TRS_MODE_MSB:`TRS_MODE_LSB]);

  // Reserved positions stay tied low
  assign events[`TRS_BIT_CAPB_EVENT]   = CAPB_EVENT;
  assign events[`TRS_BIT_CAPB_MATCH]   = CAPB_MATCH;
  assign events[`TRS_BIT_TMRB_TIMEOUT] = TMRB_TIMEOUT;
  assign events[7:5]                   = 3'h0;
  assign events[`TRS_BIT_TMRA_MATCH]   = match_pulse;
  assign events[`TRS_BIT_CLOCK_EVENT]  = CLOCK_EVENT;
  assign events[`TRS_BIT_CAPA_EVENT]   = CAPA_EVENT;
  assign events[`TRS_BIT_CAPA_MATCH]   = CAPA_MATCH;
  assign events[`TRS_BIT_TMRA_TIMEOUT] = TMRA_TIMEOUT;

  // Write-one-to-clear; zeros in the written word leave flags alone
  assign raw_clr = (wr_done && (sel == `TRS_SEL_CLEAR)) ?
                   (PWDATA[`TRS_FLAG_W-1:0] & `TRS_FLAG_MASK) : `TRS_RST_FLAGS;

  // Reading the interrupt status clears the flags held when the transfer completes, one cycle after the returned word was sampled
  assign irq_clr = (rd_done && (sel == `TRS_SEL_IRQ_STAT)) ? irq_flags : `TRS_RST_FLAGS;

  // Raw flags ignore the mask entirely
  trs_flags u_raw
  (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .set   (events),
    .clr   (raw_clr),
    .flags (raw_flags)
  );

  trs_flags u_irq
  (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .set   (events),
    .clr   (irq_clr),
    .flags (irq_flags)
  );

  assign RAW_FLAGS = raw_flags;

  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      equal_r <= 1'b0;
    end
    else
    begin
      equal_r <= equal_now;
    end
  end

  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      mode_r <= `TRS_RST_MODE;
    end
    else if (wr_done && (sel == `TRS_SEL_MODE))
    begin
      mode_r <= PWDATA & `TRS_MODE_MASK;
    end
  end

  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      match_r <= `TRS_RST_MATCH;
    end
    else if (wr_done && (sel == `TRS_SEL_MATCH))
    begin
      match_r <= PWDATA;
    end
  end

  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      irq_mask_r <= `TRS_RST_MASK;
    end
    else if (wr_done && (sel == `TRS_SEL_IRQ_MASK))
    begin
      irq_mask_r <= PWDATA[`TRS_FLAG_W-1:0] & `TRS_FLAG_MASK;
    end
  end

  // Read mux; the clear register is write-only and reads zero
  always @*
  begin
    rdata_nxt  = 32'h0000_0000;
    slverr_nxt = 1'b0;
    case (sel)
      `TRS_SEL_MODE:     rdata_nxt = mode_r;
      `TRS_SEL_RAW:      rdata_nxt = trs_word(raw_flags);
      `TRS_SEL_CLEAR:    rdata_nxt = 32'h0000_0000;
      `TRS_SEL_MATCH:    rdata_nxt = match_r;
      `TRS_SEL_IRQ_STAT: rdata_nxt = trs_word(irq_flags);
      `TRS_SEL_IRQ_MASK: rdata_nxt = trs_word(irq_mask_r);
      default:           slverr_nxt = 1'b1;
    endcase
  end

  // Writes to the read-only raw register are refused with an error
  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (access && !PREADY)
    begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_nxt;
      PSLVERR <= slverr_nxt | (PWRITE & (sel == `TRS_SEL_RAW));
    end
    else
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // Registered output, so the line lags the status by one cycle
  always @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(irq_flags & irq_mask_r);
    end
  end

endmodule

`default_nettype wire

/* dv/trs_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module trs_checker
(
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CAPB_EVENT,
  input wire logic        CAPB_MATCH,
  input wire logic        TMRB_TIMEOUT,
  input wire logic        CLOCK_EVENT,
  input wire logic        CAPA_EVENT,
  input wire logic        CAPA_MATCH,
  input wire logic        TMRA_TIMEOUT,
  input wire logic [10:0] RAW_FLAGS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire logic [10:0] evv = {CAPB_EVENT, CAPB_MATCH, TMRB_TIMEOUT, 4'h0, CLOCK_EVENT, CAPA_EVENT, CAPA_MATCH, TMRA_TIMEOUT};
  logic      [10:0] raw_q;
  always @(posedge REF_CLK)
    raw_q <= RAW_FLAGS;
  wire logic [10:0] fell = raw_q & ~RAW_FLAGS;
  wire logic        wclr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h024;
  chk_ev_sets: assert property (|evv |=> (RAW_FLAGS & $past(evv)) == $past(evv))
    else $error("event did not set its flag");
  chk_clr_works: assert property (wclr |=> (RAW_FLAGS & $past(PWDATA[10:0]) & ~$past(evv) & 11'h70F) == 11'h000)
    else $error("written one did not clear flag");
  chk_flag_holds: assert property ($past(RST_N) && fell != 11'h000 |-> $past(wclr) && (fell & ~$past(PWDATA[10:0])) == 11'h000)
    else $error("flag dropped without clear");
  chk_set_wins: assert property (wclr && (evv & PWDATA[10:0]) != 11'h000 |=> (RAW_FLAGS & $past(evv)) == $past(evv))
    else $error("event lost against clear");
  chk_rsvd_zero: assert property (RAW_FLAGS[7:5] == 3'h0)
    else $error("reserved flag bits not zero");
  chk_one_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  chk_raw_ro: assert property (PREADY && PSEL && PWRITE && PADDR == 12'h01C |-> PSLVERR)
    else $error("write to raw flags not refused");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero while idle");
  cover property (wclr && (evv & PWDATA[10:0]) != 11'h000);
  cover property (PREADY && PSLVERR);
  cover property ($rose(RAW_FLAGS[4]));
endmodule
bind trs_top trs_checker trs_checker_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CAPB_EVENT(CAPB_EVENT), .CAPB_MATCH(CAPB_MATCH), .TMRB_TIMEOUT(TMRB_TIMEOUT), .CLOCK_EVENT(CLOCK_EVENT),
  .CAPA_EVENT(CAPA_EVENT), .CAPA_MATCH(CAPA_MATCH), .TMRA_TIMEOUT(TMRA_TIMEOUT), .RAW_FLAGS(RAW_FLAGS));
`default_nettype wire

/* dv/trs_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module trs_top_bench;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rnd = 1'b0, mie_m = 1'b0, e;
  logic [1:0]  mode_m = 2'h0;
  logic [6:0]  ev_r = 7'h00, ev_p = 7'h00, ev_d = 7'h00;
  logic [10:0] exp_f;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, cnt = 32'h0, cnt_p, match_m = 32'hFFFF_FFFF, q, mv [5];
  wire  [31:0] prd;
  wire  [10:0] raw;
  wire         prdy, perr, irq;
  wire  [6:0]  ev = ev_r | ev_p | (ev_d & {7{prdy}});
  wire         wclr = psel && pen && prdy && pwr && pa == 12'h024;
  wire         mhit = mie_m && mode_m inside {2'h1, 2'h2} && cnt == match_m && cnt_p != match_m;
  int          err_total = 0, cmp_count = 0;
  trs_top trs_top_i (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .CAPB_EVENT(ev[6]), .CAPB_MATCH(ev[5]),
    .TMRB_TIMEOUT(ev[4]), .CLOCK_EVENT(ev[3]), .CAPA_EVENT(ev[2]), .CAPA_MATCH(ev[1]), .TMRA_TIMEOUT(ev[0]),
    .TMRA_COUNT(cnt), .RAW_FLAGS(raw), .IRQ(irq));
  always #5 clk = ~clk;
  function automatic logic [10:0] flag_next(input logic [10:0] f, c, input logic [6:0] v, input logic m);
    return (f & ~c) | {v[6:4], 3'h0, m, v[3:0]};
  endfunction
  task automatic chk(input logic [32:0] g, x);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Flag model; bit 4 left to register reads since its edge depends on the count history
  always @(posedge clk)
  begin
    ev_r <= rnd ? 7'($urandom & $urandom) : 7'h00;
    cnt_p <= cnt;
    exp_f <= rst_n ? flag_next(exp_f, wclr ? pwd[10:0] : 11'h000, ev, mhit) : 11'h000;
    if (rst_n)
      chk(raw & 11'h7EF, exp_f & 11'h7EF);
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 50);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50)
      err_total++;
    if (w && !e && a == 12'h004)
      {mie_m, mode_m} = {d[5], d[1:0]};
    if (w && !e && a == 12'h030)
      match_m = d;
  endtask
  task automatic pulse(input logic [6:0] v);
    ev_p <= v;
    @(posedge clk);
    ev_p <= 7'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic rcheck;
    logic [11:0] ra [4] = '{12'h01C, 12'h004, 12'h030, 12'h044};
    logic [31:0] rv [4] = '{32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0};
    {mie_m, mode_m, match_m} = {3'h0, 32'hFFFF_FFFF};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100us;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
  initial
  begin
    void'($urandom(18150));
    mv = '{32'h21, 32'h20, 32'h22, 32'h23, 32'h01};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rcheck();
    apb(1'b0, 12'h0F0, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    $display("test reset done");
    rnd <= 1'b1;
    repeat (60)
    begin
      ev_d <= 7'($urandom);
      apb(1'b1, 12'h024, $urandom);
    end
    rnd <= 1'b0;
    ev_d <= 7'h00;
    apb(1'b0, 12'h01C, 32'h0);
    chk(q, exp_f);
    $display("test random done");
    apb(1'b0, 12'h040, 32'h0);
    apb(1'b1, 12'h044, 32'h8);
    pulse(7'h04);
    chk(irq, 1'b0);
    pulse(7'h08);
    chk(irq, 1'b1);
    apb(1'b0, 12'h040, 32'h0);
    chk(q, 32'hC);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    ev_d <= 7'h7F;
    apb(1'b1, 12'h024, 32'h71F);
    ev_d <= 7'h00;
    @(posedge clk);
    chk(raw, 11'h70F);
    $display("test irq done");
    for (int i = 0; i < 5; i++)
    begin
      cnt <= 32'h0;
      apb(1'b1, 12'h004, mv[i] | 32'hD0);
      apb(1'b0, 12'h004, 32'h0);
      chk(q, mv[i]);
      apb(1'b1, 12'h030, $urandom);
      apb(1'b1, 12'h024, 32'h10);
      cnt <= match_m;
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h01C, 32'h0);
      chk(q, exp_f);
      apb(1'b1, 12'h024, 32'h10);
      apb(1'b0, 12'h01C, 32'h0);
      chk(q, exp_f);
    end
    $display("test match done");
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rcheck();
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
